// *** hw/iasic_top.sv ***
`timescale 1ns/10ps
module iasic_top
    import iasic_pkg::*;
#(
    parameter int MS_CYCLES = CYC_PER_MS
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  irq_in_u0,
    input  wire logic [7:0]  irq_in_u1,
    output logic             svc_start,
    output logic [7:0]       svc_vector,
    output logic             svc_busy,
    output logic             fault_indicator,
    output logic             irq,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]  aw_addr_reg;
    logic        aw_full_reg;
    logic [31:0] w_data_reg;
    logic        w_full_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] ctrl_reg;
    logic [16:0] result_reg;
    logic [1:0]  tb_cfg_reg;
    logic [15:0] interval_bcd_reg;
    logic [15:0] mask_reg;
    logic [15:0] pend_reg;
    logic        sched_pend_reg;
    logic        gmask_reg;
    logic        busy_reg;
    logic [7:0]  vector_reg;
    logic        start_reg;
    logic [2:0]  stat_reg;
    logic [2:0]  imask_reg;
    logic [15:0] sync1_reg;
    logic [15:0] sync2_reg;
    logic [15:0] prev_reg;
    logic [16:0] div_reg;

    iasic_sched_if sif ();

    iasic_sched_timer u_timer (
        .clk   (clk),
        .rst_b (rst_b),
        .sif   (sif)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        wr_go   = aw_full_reg && w_full_reg && !bvalid_reg;
    wire        rd_go   = s_axi_arvalid && !rvalid_reg;
    wire        wr_ctrl = wr_go && (aw_addr_reg == ADDR_CMD_CTRL);
    wire        exec    = wr_go && (aw_addr_reg == ADDR_CMD_DATA);
    wire        wr_cfg  = wr_go && (aw_addr_reg == ADDR_TB_CFG);
    wire        wr_svc  = wr_go && (aw_addr_reg == ADDR_SVC);
    wire        wr_stat = wr_go && (aw_addr_reg == ADDR_IRQ_STAT);
    wire        wr_imsk = wr_go && (aw_addr_reg == ADDR_IRQ_MASK);
    wire        wr_rdon = wr_go && ((aw_addr_reg == ADDR_RESULT)
                          || (aw_addr_reg == ADDR_PENDING));
    wire        wr_hit  = wr_ctrl || exec || wr_cfg || wr_svc || wr_stat || wr_imsk
                          || wr_rdon;
    wire        rd_hit  = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[1:0] == 2'h0);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire [11:0] code    = ctrl_reg[11:0];
    wire [11:0] sel     = ctrl_reg[CTRL_SEL_LSB +: 12];
    wire [15:0] cdata   = w_data_reg[15:0];
    wire        c_mask  = code == CODE_MASK;
    wire        c_clr   = code == CODE_CLEAR;
    wire        c_read  = code == CODE_READ;
    wire        c_glob  = (code == CODE_MASK_ALL) || (code == CODE_UNMASK);
    wire        s_unit  = (sel == SEL_UNIT0) || (sel == SEL_UNIT1);
    wire        s_tmr   = sel == SEL_TIMER;
    wire        unit1   = sel == SEL_UNIT1;
    wire        d_bcd   = bcd_ok(cdata);
    wire        bad     = !(c_glob || ((c_mask || c_clr || c_read) && (s_unit || s_tmr)))
                          || (!c_glob && s_unit && (c_mask || c_clr) && cdata[15:8] != 8'h00)
                          || (!c_glob && s_tmr && c_mask && (!d_bcd || cdata == 16'h0000))
                          || (!c_glob && s_tmr && c_clr && !d_bcd);
    wire        ok      = exec && !bad;
    wire        do_mask = ok && s_unit && c_mask;
    wire        do_clr  = ok && s_unit && c_clr;
    wire        do_rdm  = ok && s_unit && c_read;
    wire        do_ivl  = ok && s_tmr && c_mask;
    wire        do_fst  = ok && s_tmr && c_clr;
    wire        do_rdi  = ok && s_tmr && c_read;
    wire [15:0] clr_vec = do_clr ? (unit1 ? {cdata[7:0], 8'h00} : {8'h00, cdata[7:0]})
                                 : 16'h0000;
    wire [7:0]  unit_mask = unit1 ? mask_reg[15:8] : mask_reg[7:0];

    // ------------------------------------------------------------
    // Input events and dispatch
    // ------------------------------------------------------------
    wire [15:0] edge_in  = sync2_reg & ~prev_reg;
    wire [15:0] eligible = pend_reg & ~mask_reg;
    wire        any_in   = |eligible;
    wire        can_go   = !busy_reg && !gmask_reg;
    wire        disp     = can_go && (any_in || sched_pend_reg);
    wire [15:0] win      = eligible & (~eligible + 16'h0001);
    wire [15:0] svc_clr  = (disp && any_in) ? win : 16'h0000;
    wire        sched_go = disp && !any_in;
    wire [16:0] half_ms  = 17'(MS_CYCLES - 1);

    function automatic logic [7:0] onehot_idx(input logic [15:0] v);
        onehot_idx = 8'h00;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                onehot_idx = 8'(i);
            end
        end
    endfunction

    assign sif.ms_pulse    = div_reg == half_ms;
    // 10 ms unless enabled and 1 ms
    assign sif.unit_10ms   = !(tb_cfg_reg[0] && tb_cfg_reg[1]);
    assign sif.ld_interval = do_ivl;
    assign sif.ld_first    = do_fst;
    assign sif.value_bin   = bcd2bin(cdata);

    // ------------------------------------------------------------
    // Bus handshake, service and interrupt outputs
    // ------------------------------------------------------------
    assign s_axi_awready   = !aw_full_reg;
    assign s_axi_wready    = !w_full_reg;
    assign s_axi_bvalid    = bvalid_reg;
    assign s_axi_bresp     = bresp_reg;
    assign s_axi_arready   = !rvalid_reg;
    assign s_axi_rvalid    = rvalid_reg;
    assign s_axi_rdata     = rdata_reg;
    assign s_axi_rresp     = rresp_reg;
    assign svc_start       = start_reg;
    assign svc_vector      = vector_reg;
    assign svc_busy        = busy_reg;
    assign fault_indicator = result_reg[RESULT_FAULT];
    assign irq             = |(stat_reg & imask_reg);

    // ------------------------------------------------------------
    // Write channel and response
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aw_addr_reg <= 8'h00;
            aw_full_reg <= 1'b0;
            w_data_reg  <= 32'h00000000;
            w_full_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
        end else begin
            if (s_axi_awvalid && !aw_full_reg) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
            end
            if (s_axi_wvalid && !w_full_reg) begin
                w_data_reg <= s_axi_wdata;
                w_full_reg <= 1'b1;
            end
            if (wr_go) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_hit ? 2'h0 : 2'h2;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Strobes ignored: every register is written as a whole word
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= 2'h0;
        end else if (rd_go) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_hit ? 2'h0 : 2'h2;
            if (s_axi_araddr == ADDR_CMD_CTRL) begin
                rdata_reg <= ctrl_reg;
            end else if (s_axi_araddr == ADDR_RESULT) begin
                rdata_reg <= {15'h0000, result_reg};
            end else if (s_axi_araddr == ADDR_TB_CFG) begin
                rdata_reg <= {30'h00000000, tb_cfg_reg};
            end else if (s_axi_araddr == ADDR_SVC) begin
                rdata_reg <= {23'h000000, busy_reg, vector_reg};
            end else if (s_axi_araddr == ADDR_IRQ_STAT) begin
                rdata_reg <= {29'h00000000, stat_reg};
            end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
                rdata_reg <= {29'h00000000, imask_reg};
            end else if (s_axi_araddr == ADDR_PENDING) begin
                rdata_reg <= {14'h0000, gmask_reg, sched_pend_reg, pend_reg};
            end else begin
                rdata_reg <= 32'h00000000;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Command registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_reg         <= 32'h00000000;
            tb_cfg_reg       <= 2'h0;
            imask_reg        <= 3'h0;
            result_reg       <= 17'h00000;
            interval_bcd_reg <= 16'h0000;
            mask_reg         <= MASK_RESET;
            gmask_reg        <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_reg <= w_data_reg;
            if (wr_cfg) tb_cfg_reg <= w_data_reg[1:0];
            if (wr_imsk) imask_reg <= w_data_reg[2:0];
            if (exec) result_reg[RESULT_FAULT] <= bad;
            if (do_rdm) result_reg[15:0] <= {8'h00, unit_mask};
            if (do_rdi) result_reg[15:0] <= interval_bcd_reg;
            if (do_ivl) interval_bcd_reg <= cdata;
            if (do_mask && unit1) mask_reg[15:8] <= cdata[7:0];
            if (do_mask && !unit1) mask_reg[7:0] <= cdata[7:0];
            if (ok && c_glob) gmask_reg <= (code == CODE_MASK_ALL);
        end
    end

    // ------------------------------------------------------------
    // Pending latches and service
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1_reg      <= 16'h0000;
            sync2_reg      <= 16'h0000;
            prev_reg       <= 16'h0000;
            pend_reg       <= 16'h0000;
            sched_pend_reg <= 1'b0;
            busy_reg       <= 1'b0;
            start_reg      <= 1'b0;
            vector_reg     <= 8'h00;
            stat_reg       <= 3'h0;
            div_reg        <= 17'h00000;
        end else begin
            sync1_reg <= {irq_in_u1, irq_in_u0};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
            div_reg   <= sif.ms_pulse ? 17'h00000 : div_reg + 17'h00001;
            pend_reg  <= (pend_reg & ~clr_vec & ~svc_clr) | edge_in;
            sched_pend_reg <= (sched_pend_reg && !sched_go) || sif.tick;
            start_reg <= disp;
            if (disp) begin
                busy_reg   <= 1'b1;
                vector_reg <= any_in ? onehot_idx(win) : VEC_SCHED;
            end else if (wr_svc) begin
                busy_reg <= 1'b0;
            end
            // Hardware set wins over software clear
            stat_reg <= (stat_reg & ~(wr_stat ? w_data_reg[2:0] : 3'h0))
                        | {sif.tick, exec && bad, disp};
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    masked_reset_a: assert property (@(posedge clk)
        $rose(rst_b) |-> mask_reg == MASK_RESET)
        else $error("inputs not all masked after reset");

    mask_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        (do_mask && !unit1) |=> mask_reg[7:0] == $past(cdata[7:0]))
        else $error("mask write did not load unit 0 mask");

    read_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
        do_rdm |=> result_reg[7:0] == $past(unit_mask))
        else $error("read mask returned wrong bits");

    fault_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
        (exec && bad) |=> fault_indicator && $stable(mask_reg) && $stable(gmask_reg))
        else $error("bad command not faulted or acted");

    global_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (gmask_reg && clr_vec == 16'h0000)
        |=> !start_reg && ((pend_reg & $past(pend_reg)) == $past(pend_reg)))
        else $error("latched request lost or served while globally masked");

    no_preempt_a: assert property (@(posedge clk) disable iff (!rst_b)
        (busy_reg && !wr_svc) |=> busy_reg && !start_reg)
        else $error("running routine was preempted");

    clear_pend_a: assert property (@(posedge clk) disable iff (!rst_b)
        (do_clr && !unit1) |=> (pend_reg[7:0] & $past(cdata[7:0] & ~edge_in[7:0])) == 8'h00)
        else $error("clear left request latched");

    immediate_svc_a: assert property (@(posedge clk) disable iff (!rst_b)
        (can_go && eligible != 16'h0000) |=> start_reg && vector_reg[7:4] == 4'h0)
        else $error("unmasked input request not dispatched next cycle");

endmodule

// *** hw/iasic_pkg.sv ***
package iasic_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_CMD_DATA  = 8'h04;
    localparam logic [7:0] ADDR_RESULT    = 8'h08;
    localparam logic [7:0] ADDR_TB_CFG    = 8'h0c;
    localparam logic [7:0] ADDR_SVC       = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;
    localparam logic [7:0] ADDR_PENDING   = 8'h1c;

    // ------------------------------------------------------------
    // Command codes and unit selectors (BCD digits)
    // ------------------------------------------------------------
    localparam logic [11:0] CODE_MASK     = 12'h000;
    localparam logic [11:0] CODE_CLEAR    = 12'h001;
    localparam logic [11:0] CODE_READ     = 12'h002;
    localparam logic [11:0] CODE_MASK_ALL = 12'h100;
    localparam logic [11:0] CODE_UNMASK   = 12'h200;
    localparam logic [11:0] SEL_UNIT0     = 12'h000;
    localparam logic [11:0] SEL_UNIT1     = 12'h001;
    localparam logic [11:0] SEL_TIMER     = 12'h004;

    // ------------------------------------------------------------
    // Field positions, reset values, vectors
    // ------------------------------------------------------------
    localparam int          CTRL_SEL_LSB   = 16;
    localparam int          RESULT_FAULT   = 16;
    localparam int          SVC_BUSY_BIT   = 8;
    localparam int          STAT_DISPATCH  = 0;
    localparam int          STAT_FAULT     = 1;
    localparam int          STAT_TICK      = 2;
    localparam int          PEND_SCHED     = 16;
    localparam int          PEND_GMASK     = 17;
    localparam logic [15:0] MASK_RESET     = 16'hffff;
    localparam logic [7:0]  VEC_SCHED      = 8'h63;
    localparam logic [16:0] UNIT_10MS_MULT = 17'h0000a;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS         = 1000000;
    localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

    function automatic logic bcd_ok(input logic [15:0] v);
        bcd_ok = (v[3:0] < 4'ha) && (v[7:4] < 4'ha) && (v[11:8] < 4'ha)
                 && (v[15:12] < 4'ha);
    endfunction

    function automatic logic [13:0] bcd2bin(input logic [15:0] v);
        bcd2bin = 14'(v[15:12]) * 14'd1000 + 14'(v[11:8]) * 14'd100
                  + 14'(v[7:4]) * 14'd10 + 14'(v[3:0]);
    endfunction

endpackage

// *** hw/iasic_sched_if.sv ***
`timescale 1ns/10ps
interface iasic_sched_if;
    logic        ms_pulse;
    logic        unit_10ms;
    logic        ld_interval;
    logic        ld_first;
    logic [13:0] value_bin;
    logic        tick;

    modport ctl (output ms_pulse, unit_10ms, ld_interval, ld_first, value_bin, input tick);
    modport tmr (input ms_pulse, unit_10ms, ld_interval, ld_first, value_bin, output tick);
endinterface

// *** hw/iasic_sched_timer.sv ***
`timescale 1ns/10ps
module iasic_sched_timer
    import iasic_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    iasic_sched_if.tmr sif
);

    logic [16:0] interval_reg;
    logic [16:0] remain_reg;
    logic        tick_reg;
    wire  [16:0] scaled;
    wire         expire;

    // ------------------------------------------------------------
    // Scaling by time unit
    // ------------------------------------------------------------
    // value times unit
    assign scaled = sif.unit_10ms ? 17'(17'(sif.value_bin) * UNIT_10MS_MULT)
                                  : 17'(sif.value_bin);
    assign expire = sif.ms_pulse && (interval_reg != 17'h00000) && (remain_reg <= 17'h00001);
    assign sif.tick = tick_reg;

    // ------------------------------------------------------------
    // Countdown
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            interval_reg <= 17'h00000;
            remain_reg   <= 17'h00000;
            tick_reg     <= 1'b0;
        end else begin
            tick_reg <= expire;
            if (sif.ld_interval) begin
                interval_reg <= scaled;
                remain_reg   <= scaled;
            end else if (sif.ld_first) begin
                remain_reg <= scaled;
            end else if (expire) begin
                remain_reg <= interval_reg;
            end else if (sif.ms_pulse && remain_reg != 17'h00000) begin
                remain_reg <= remain_reg - 17'h00001;
            end
        end
    end

    idle_no_tick_a: assert property (@(posedge clk) disable iff (!rst_b)
        (interval_reg == 17'h00000) |=> !tick_reg)
        else $error("scheduled tick while interval is zero");

endmodule

// *** testbench/iasic_irq_src.sv ***
`timescale 1ns/10ps
// ----
// Interrupt input units
// ----
module iasic_irq_src (
    input  wire logic       clk,
    output logic      [7:0] u0,
    output logic      [7:0] u1
);
    initial {u1, u0} = 16'h0000;
    // Rising edges only
    // Held four cycles so the two-stage sync sees it
    task automatic fire(input logic [15:0] b);
        @(posedge clk) {u1, u0} <= b;
        repeat (4) @(posedge clk);
        {u1, u0} <= 16'h0000;
    endtask
endmodule

// *** testbench/input_and_scheduled_irq_control_test.sv ***
`timescale 1ns/10ps
module input_and_scheduled_irq_control_test;
    import iasic_pkg::*;
    localparam int MSC = 20;
    logic        clk = 1'b0, rst_b = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, u0, u1, svc_vector, last_vec;
    logic [31:0] wdata = 32'h0, rdata, r;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, svc_start, svc_busy;
    logic        fault_indicator, irq;
    logic [1:0]  bresp, rresp, rs, ws;
    int          n_fail = 0, checks_done = 0, n_svc = 0, cyc = 0, t_svc = 0;
    logic [39:0] bad [4] = '{{12'h003, SEL_UNIT0, 16'h0}, {CODE_MASK, 12'h002, 16'h0},
                            {CODE_MASK, SEL_UNIT0, 16'h0100}, {CODE_MASK, SEL_TIMER, 16'h12a4}};

    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (svc_start === 1'b1) begin
            n_svc <= n_svc + 1;
            last_vec <= svc_vector;
            t_svc <= cyc;
        end
    end

    iasic_irq_src src (.clk(clk), .u0(u0), .u1(u1));
    iasic_top #(.MS_CYCLES(MSC)) dut (.clk(clk), .rst_b(rst_b), .irq_in_u0(u0), .irq_in_u1(u1),
        .svc_start(svc_start), .svc_vector(svc_vector), .svc_busy(svc_busy),
        .fault_indicator(fault_indicator), .irq(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ----
    // Bus and compare helpers
    // ----
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    // Readies sampled mid-cycle; inputs only move after rising edges
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(negedge clk);
            {aw, w, b, ws} = {awready, wready, bvalid, bresp};
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while (!b);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic v, ar;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(negedge clk);
            {v, ar, r, rs} = {rvalid, arready, rdata, rresp};
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
        end while (!v);
        rready <= 1'b0;
    endtask
    task automatic cmd(input logic [11:0] c, input logic [11:0] s, input logic [15:0] d);
        wr(ADDR_CMD_CTRL, {4'h0, s, 4'h0, c});
        wr(ADDR_CMD_DATA, {16'h0000, d});
    endtask
    task automatic wsvc(input int n, input logic [7:0] v, input int lim);
        repeat (lim) if (n_svc == n) @(posedge clk);
        chk(n_svc, n + 1);
        chk({24'h0, last_vec}, {24'h0, v});
    endtask
    task automatic per(input int e);
        int n, t;
        for (int i = 0; i < 3; i++) begin
            n = n_svc;
            t = t_svc;
            wr(ADDR_SVC, 32'h0);
            wsvc(n, VEC_SCHED, 400);
        end
        chk(t_svc - t, e);
        wr(ADDR_SVC, 32'h0);
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        cmd(CODE_READ, SEL_UNIT0, 16'h0);
        rd(ADDR_RESULT); chk(r, 32'hff);
        cmd(CODE_READ, SEL_TIMER, 16'h0);
        rd(ADDR_RESULT); chk(r, 32'h0);
    endtask
    task automatic t_mask;
        cmd(CODE_MASK, SEL_UNIT1, 16'h00a5);
        cmd(CODE_READ, SEL_UNIT1, 16'h0);
        rd(ADDR_RESULT); chk(r, 32'ha5);
        cmd(CODE_MASK, SEL_UNIT1, 16'h00ff);
    endtask
    task automatic t_latch;
        int n;
        n = n_svc;
        src.fire(16'h0008);
        repeat (4) @(posedge clk);
        chk(n_svc, n);
        rd(ADDR_PENDING); chk(r, 32'h8);
        cmd(CODE_MASK, SEL_UNIT0, 16'h00f7);
        wsvc(n, 8'h03, 60);
        rd(ADDR_PENDING); chk(r, 32'h0);
        chk(svc_busy, 1'b1);
        wr(ADDR_SVC, 32'h0);
        chk(svc_busy, 1'b0);
    endtask
    task automatic t_prio;
        int n;
        cmd(CODE_MASK_ALL, 12'h000, 16'h0);
        src.fire(16'h0106);
        repeat (4) @(posedge clk);
        cmd(CODE_CLEAR, SEL_UNIT0, 16'h0002);
        rd(ADDR_PENDING); chk(r, 32'h20104);
        cmd(CODE_MASK, SEL_UNIT0, 16'h0);
        cmd(CODE_MASK, SEL_UNIT1, 16'h0);
        n = n_svc;
        cmd(CODE_UNMASK, 12'h000, 16'h0);
        wsvc(n, 8'h02, 60);
        repeat (20) @(posedge clk);
        chk(n_svc, n + 1);
        n = n_svc;
        wr(ADDR_SVC, 32'h0);
        wsvc(n, 8'h08, 60);
        wr(ADDR_SVC, 32'h0);
    endtask
    task automatic t_fault;
        wr(ADDR_IRQ_MASK, 32'h2);
        foreach (bad[i]) begin
            cmd(bad[i][39:28], bad[i][27:16], bad[i][15:0]);
            chk(fault_indicator, 1'b1);
            cmd(CODE_READ, SEL_UNIT0, 16'h0);
            chk(fault_indicator, 1'b0);
        end
        chk(irq, 1'b1);
        wr(ADDR_IRQ_STAT, 32'h2);
        chk(irq, 1'b0);
        cmd(CODE_READ, SEL_UNIT1, 16'h0);
        rd(ADDR_RESULT); chk(r, 32'h0);
        rd(8'h20); chk(rs, 2'b10);
        wr(8'h20, 32'h0); chk(ws, 2'b10);
    endtask
    task automatic t_timer;
        int n, c0;
        wr(ADDR_TB_CFG, 32'h3);
        cmd(CODE_MASK, SEL_TIMER, 16'h0003);
        cmd(CODE_CLEAR, SEL_TIMER, 16'h0000);
        cmd(CODE_READ, SEL_TIMER, 16'h0);
        rd(ADDR_RESULT); chk(r, 32'h3);
        per(3 * MSC);
        wr(ADDR_TB_CFG, 32'h2);
        cmd(CODE_MASK, SEL_TIMER, 16'h0001);
        cmd(CODE_CLEAR, SEL_TIMER, 16'h0002);
        c0 = cyc;
        n = n_svc;
        wr(ADDR_SVC, 32'h0);
        // Tick to dispatch adds three cycles; the first ms is partial
        wsvc(n, VEC_SCHED, 500);
        chk((t_svc - c0 - 3) / MSC, 2 * 10 - 1);
        per(10 * MSC);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_mask;
        t_latch;
        t_prio;
        t_fault;
        t_timer;
        print_verdict;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict;
    end
endmodule
